// ===== arc_defines.vh
// constants for the alarm routing and carrier control block
// included by arc_top.v; definitions only
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH
// register word offsets
`define ARC_OFF_ROUTE    4'h0
`define ARC_OFF_TEST     4'h1
`define ARC_OFF_TXCFG    4'h2
`define ARC_OFF_UPC      4'h3
`define ARC_OFF_STATUS   4'h4
`define ARC_OFF_IRQ_ST   4'h5
`define ARC_OFF_IRQ_MASK 4'h6
`define ARC_OFF_FWUPD    4'h7
`define ARC_OFF_SERIAL   4'h8
// route register fields
`define ARC_RT_REF_LSB   0
`define ARC_RT_OVEN_LSB  3
`define ARC_RT_TST_LSB   6
`define ARC_RT_HW_LSB    8
`define ARC_RT_BEEP_LSB  10
// tx config fields
`define ARC_TX_EN_BIT    0
`define ARC_TX_MOD_LSB   1
`define ARC_TX_SPEC_BIT  4
`define ARC_TX_MASK_BIT  5
`define ARC_TX_BURST_BIT 6
`define ARC_TX_PRE_BIT   7
`define ARC_TX_UPC_BIT   8
`define ARC_TX_MUTE_LSB  9
// uplink loop set point in tenths of dB, then preamble lengths in symbols
`define ARC_UPC_MIN_DB10 9'h01E
`define ARC_UPC_MAX_DB10 9'h0C8
`define ARC_UPC_RST_DB10 9'h041
`define ARC_PRE_SHORT    7'h20
`define ARC_PRE_LONG     7'h40
// reset values
`define ARC_ROUTE_RST    32'h0000_0000
`define ARC_TXCFG_RST    32'h0000_0002
`define ARC_LVL_RST      8'h80
`endif

// ===== arc_top.v
// alarm routing, beeper, test select and transmit carrier control
// assumes an avalon-mm master on sys_clk_in and synchronous status inputs
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "arc_defines.vh"
module arc_top (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // avalon-mm slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // alarm sources and status
  input  wire        ref_alarm_in,
  input  wire        oven_oscillator_alarm_in,
  input  wire        hw_alarm_in,
  input  wire        burst_option_in,
  input  wire        data_present_in,
  input  wire        clk_external_in,
  input  wire        clk_ok_in,
  input  wire        far_ebno_valid_in,
  input  wire [8:0]  far_ebno_db10_in,
  // outputs
  output reg         alarm_a_out,
  output reg         alarm_b_out,
  output reg         carrier_mute_out,
  output reg         beep_out,
  output reg         lamp_test_out,
  output reg         self_test_out,
  output reg         carrier_on_out,
  output reg  [2:0]  modulation_out,
  output reg         spectrum_inv_out,
  output reg         legacy_mask_out,
  output reg         burst_mode_out,
  output reg  [6:0]  preamble_len_out,
  output reg  [7:0]  tx_level_out,
  output reg         fw_update_start_out,
  output reg         irq_out
);

  // decode of an eight-value route code into {mute, b, a}
  function [2:0] route3;
    input [2:0] code;
    input       src;
    begin
      route3 = src ? code : 3'h0;
    end
  endfunction

  // registers
  reg [11:0] route_q;
  reg [1:0]  test_q;
  reg [10:0] txcfg_q;
  reg [8:0]  upc_set_q;
  reg [7:0]  upc_max_q;
  reg [7:0]  upc_min_q;
  reg [3:0]  irq_st_q;
  reg [3:0]  irq_mask_q;
  reg [31:0] serial_q;
  reg        serial_ok_q;
  reg        mute_hold_q;
  reg        pwr_q;
  reg        acc_q;
  reg        a_q;
  reg        b_q;
  reg        m_q;
  reg        tst_q;
  reg [7:0]  lvl_q;

  parameter [31:0] UNIT_SERIAL = 32'h0000_1234; // arbitrary unit serial

  wire        wr = avs_write_in & acc_q;
  // read data is loaded as the request is taken, so it stands when waitrequest is seen low
  wire        rd = avs_read_in & ~acc_q;
  wire [2:0]  ref_r;
  wire [2:0]  ov_r;
  wire [1:0]  ts_r;
  wire [1:0]  hw_r;
  wire        tst_act;
  wire        a_d;
  wire        b_d;
  wire        m_d;
  wire [1:0]  mute_pol = txcfg_q[`ARC_TX_MUTE_LSB +: 2];
  wire [2:0]  mod_w = avs_writedata_in[`ARC_TX_MOD_LSB +: 3];
  wire        mod_ok = (mod_w <= 3'h3) | (mod_w == 3'h6);
  wire [10:0] tx_new;

  assign tst_act = (test_q != 2'h0);
  assign ref_r = route3(route_q[`ARC_RT_REF_LSB +: 3], ref_alarm_in);
  assign ov_r = route3(route_q[`ARC_RT_OVEN_LSB +: 3], oven_oscillator_alarm_in);
  assign ts_r = tst_act ? route_q[`ARC_RT_TST_LSB +: 2] : 2'h0;
  assign hw_r = hw_alarm_in ? route_q[`ARC_RT_HW_LSB +: 2] : 2'h0;
  assign a_d = ref_r[0] | ov_r[0] | ts_r[0] | hw_r[0];
  assign b_d = ref_r[1] | ov_r[1] | ts_r[1] | hw_r[1];
  assign m_d = ref_r[2] | ov_r[2];

  // reserved modulation codes keep old value
  // burst bit forced low without option
  assign tx_new = {avs_writedata_in[10:8],
                   avs_writedata_in[`ARC_TX_PRE_BIT],
                   avs_writedata_in[`ARC_TX_BURST_BIT] & burst_option_in,
                   avs_writedata_in[5:4],
                   mod_ok ? mod_w : txcfg_q[3:1],
                   avs_writedata_in[0]};

  // bus handshake: one wait cycle then answer
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      acc_q <= (avs_read_in | avs_write_in) & ~acc_q;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~acc_q);
    end
  end

  // register writes and side effects
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      route_q <= 12'h000;
      test_q <= 2'h0;
      txcfg_q <= 11'h002;
      upc_set_q <= `ARC_UPC_RST_DB10;
      upc_max_q <= 8'hFF;
      upc_min_q <= 8'h00;
      irq_mask_q <= 4'h0;
      serial_q <= 32'h0000_0000;
      serial_ok_q <= 1'b0;
      fw_update_start_out <= 1'b0;
      mute_hold_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      fw_update_start_out <= 1'b0;
      pwr_q <= 1'b1;
      // hold at power up needs policy 3 in the first cycle; reset loads policy 0, so it never sets
      if (!pwr_q && mute_pol == 2'h3)
        mute_hold_q <= 1'b1;
      if (wr) begin
        case (avs_address_in)
          `ARC_OFF_ROUTE: route_q <= avs_writedata_in[11:0];
          `ARC_OFF_TEST: test_q <= avs_writedata_in[1:0];
          `ARC_OFF_TXCFG: begin
            txcfg_q <= tx_new;
            // manual policies hold carrier after change
            if (mute_pol[1] && (tx_new[7:1] != txcfg_q[7:1]))
              mute_hold_q <= 1'b1;
            else if (avs_writedata_in[`ARC_TX_EN_BIT])
              mute_hold_q <= 1'b0;
          end
          `ARC_OFF_UPC: begin
            // set point clamped to 3.0 .. 20.0 dB
            if (avs_writedata_in[8:0] < `ARC_UPC_MIN_DB10)
              upc_set_q <= `ARC_UPC_MIN_DB10;
            else if (avs_writedata_in[8:0] > `ARC_UPC_MAX_DB10)
              upc_set_q <= `ARC_UPC_MAX_DB10;
            else
              upc_set_q <= avs_writedata_in[8:0];
            upc_min_q <= avs_writedata_in[23:16];
            upc_max_q <= avs_writedata_in[31:24];
          end
          `ARC_OFF_IRQ_MASK: irq_mask_q <= avs_writedata_in[3:0];
          `ARC_OFF_SERIAL: begin
            serial_q <= avs_writedata_in;
            serial_ok_q <= (avs_writedata_in == UNIT_SERIAL);
          end
          // enter starts update only after serial
          `ARC_OFF_FWUPD: begin
            if (avs_writedata_in[0] && serial_ok_q)
              fw_update_start_out <= 1'b1;
            serial_ok_q <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // uplink loop steps level toward set point
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in)
      lvl_q <= `ARC_LVL_RST;
    else if (!txcfg_q[`ARC_TX_UPC_BIT] || !far_ebno_valid_in) begin
      if (lvl_q > upc_max_q) lvl_q <= upc_max_q;
      else if (lvl_q < upc_min_q) lvl_q <= upc_min_q;
    end else if (far_ebno_db10_in < upc_set_q && lvl_q < upc_max_q)
      lvl_q <= lvl_q + 8'h01;
    else if (far_ebno_db10_in > upc_set_q && lvl_q > upc_min_q)
      lvl_q <= lvl_q - 8'h01;
    else if (lvl_q > upc_max_q)
      lvl_q <= upc_max_q;
    else if (lvl_q < upc_min_q)
      lvl_q <= upc_min_q;
  end

  // interrupt status: set on rising alarm, write one clears, set wins
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_st_q <= 4'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      m_q <= 1'b0;
      tst_q <= 1'b0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      m_q <= m_d;
      tst_q <= tst_act;
      irq_st_q <= (irq_st_q & ~((wr && avs_address_in == `ARC_OFF_IRQ_ST) ? avs_writedata_in[3:0] : 4'h0))
                | {tst_act & ~tst_q, m_d & ~m_q, b_d & ~b_q, a_d & ~a_q};
    end
  end

  // registered outputs
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_a_out <= 1'b0;
      alarm_b_out <= 1'b0;
      carrier_mute_out <= 1'b0;
      beep_out <= 1'b0;
      lamp_test_out <= 1'b0;
      self_test_out <= 1'b0;
      carrier_on_out <= 1'b0;
      modulation_out <= 3'h1;
      spectrum_inv_out <= 1'b0;
      legacy_mask_out <= 1'b0;
      burst_mode_out <= 1'b0;
      preamble_len_out <= `ARC_PRE_SHORT;
      tx_level_out <= `ARC_LVL_RST;
      irq_out <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      alarm_a_out <= a_d;
      alarm_b_out <= b_d;
      carrier_mute_out <= m_d;
      beep_out <= (route_q[`ARC_RT_BEEP_LSB] & a_d) | (route_q[`ARC_RT_BEEP_LSB + 1] & b_d);
      lamp_test_out <= test_q[0];
      self_test_out <= test_q[1];
      // carrier gated by enable, mute and hold
      carrier_on_out <= txcfg_q[`ARC_TX_EN_BIT] & ~m_d & ~mute_hold_q & pwr_q;
      modulation_out <= txcfg_q[3:1];
      spectrum_inv_out <= txcfg_q[`ARC_TX_SPEC_BIT];
      legacy_mask_out <= txcfg_q[`ARC_TX_MASK_BIT];
      burst_mode_out <= txcfg_q[`ARC_TX_BURST_BIT] & burst_option_in;
      preamble_len_out <= txcfg_q[`ARC_TX_PRE_BIT] ? `ARC_PRE_LONG : `ARC_PRE_SHORT;
      tx_level_out <= lvl_q;
      irq_out <= |(irq_st_q & irq_mask_q);
      if (rd) begin
        case (avs_address_in)
          `ARC_OFF_ROUTE: avs_readdata_out <= {20'h00000, route_q};
          `ARC_OFF_TEST: avs_readdata_out <= {30'h0, test_q};
          `ARC_OFF_TXCFG: avs_readdata_out <= {21'h0, txcfg_q};
          `ARC_OFF_UPC: avs_readdata_out <= {upc_max_q, upc_min_q, 7'h00, upc_set_q};
          `ARC_OFF_STATUS: avs_readdata_out <= {16'h0000, lvl_q, 1'b0, tst_act, clk_ok_in,
                                                clk_external_in, data_present_in, mute_hold_q,
                                                m_d, carrier_on_out};
          `ARC_OFF_IRQ_ST: avs_readdata_out <= {28'h0, irq_st_q};
          `ARC_OFF_IRQ_MASK: avs_readdata_out <= {28'h0, irq_mask_q};
          `ARC_OFF_FWUPD: avs_readdata_out <= {31'h0, serial_ok_q};
          `ARC_OFF_SERIAL: avs_readdata_out <= serial_q;
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== arc_chk_assertions.sv
// port-level checker for arc_top
// bound to every arc_top instance; one clock, async reset high
`timescale 1ns/10ps
module arc_chk (
  // clock and reset
  input wire       sys_clk_in,
  input wire       rst_in,
  // alarm sources
  input wire       ref_alarm_in,
  input wire       oven_oscillator_alarm_in,
  input wire       hw_alarm_in,
  // observed outputs
  input wire       alarm_a_out,
  input wire       alarm_b_out,
  input wire       carrier_mute_out,
  input wire       beep_out,
  input wire       lamp_test_out,
  input wire       self_test_out,
  input wire       carrier_on_out,
  input wire [2:0] modulation_out,
  input wire [6:0] preamble_len_out,
  input wire [7:0] tx_level_out,
  input wire       fw_update_start_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // only oscillator alarms may mute the carrier
  property p_mute_src; carrier_mute_out |-> $past(ref_alarm_in | oven_oscillator_alarm_in); endproperty
  a_mute_src: assert property (p_mute_src) else $error("mute without oscillator alarm");
  // output a needs a live source
  property p_a_src; alarm_a_out |-> $past(ref_alarm_in | oven_oscillator_alarm_in | hw_alarm_in)
    | lamp_test_out | self_test_out | $past(lamp_test_out | self_test_out); endproperty
  a_a_src: assert property (p_a_src) else $error("alarm a without source");
  // beeper only with a summary alarm
  property p_beep; beep_out |-> alarm_a_out | alarm_b_out | $past(alarm_a_out | alarm_b_out); endproperty
  a_beep: assert property (p_beep) else $error("beep without alarm");
  // a standing mute keeps the carrier off
  property p_mute_off; carrier_mute_out && $past(carrier_mute_out) |-> !carrier_on_out; endproperty
  a_mute_off: assert property (p_mute_off) else $error("carrier on while muted");
  // preamble is 32 or 64 symbols
  property p_pre; preamble_len_out == 7'h20 || preamble_len_out == 7'h40; endproperty
  a_pre: assert property (p_pre) else $error("bad preamble length");
  // only defined modulation codes reach the modulator
  property p_mod; modulation_out != 3'h4 && modulation_out != 3'h5 && modulation_out != 3'h7; endproperty
  a_mod: assert property (p_mod) else $error("reserved modulation code");
  // update start is a single pulse
  property p_fw; fw_update_start_out |=> !fw_update_start_out; endproperty
  a_fw: assert property (p_fw) else $error("update start too long");
  // power loop moves the level one step at a time; any other change, a jump to a max or min limit included, fails
  property p_lvl; !$stable(tx_level_out) |-> (tx_level_out - $past(tx_level_out) == 8'h01)
    || ($past(tx_level_out) - tx_level_out == 8'h01); endproperty
  a_lvl: assert property (p_lvl) else $error("level jumped");
  // main scenarios reached
  c_mute: cover property (carrier_mute_out);
  c_fw: cover property (fw_update_start_out);
  c_long: cover property (preamble_len_out == 7'h40);
endmodule
bind arc_top arc_chk i_arc_chk (.*);

// ===== arc_alarm_field.sv
// far side: alarm lines of oscillators and hardware, and the far receiver
// fault selects come from the bench; Eb/No follows the transmit level
`timescale 1ns/10ps
module arc_alarm_field (
  // fault selection and transmit level
  input  wire [2:0] fault_in,
  input  wire [7:0] tx_level_in,
  // alarm lines and far receiver report
  output wire       ref_alarm_out,
  output wire       oven_alarm_out,
  output wire       hw_alarm_out,
  output wire       ebno_valid_out,
  output wire [8:0] ebno_db10_out
);
  // one alarm line per fault bit
  assign ref_alarm_out  = fault_in[0];
  assign oven_alarm_out = fault_in[1];
  assign hw_alarm_out   = fault_in[2];
  // far Eb/No rises one tenth per level step
  assign ebno_valid_out = 1'b1;
  assign ebno_db10_out  = {1'b0, tx_level_in} - 9'h040;
endmodule

// ===== alarm_route_carrier_mute_tb.sv
// self-checking bench for arc_top
// far side is arc_alarm_field; the checker binds itself
`timescale 1ns/10ps
`include "arc_defines.vh"
module alarm_route_carrier_mute_tb;
  reg         sys_clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [3:0]  addr = 4'h0;
  reg         rd_en = 1'b0;
  reg         wr_en = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg  [2:0]  fault = 3'h0;
  reg  [2:0]  stat = 3'h0;
  reg         bopt = 1'b0;
  reg  [31:0] rd;
  wire [31:0] rdata;
  wire [8:0]  ebno;
  wire [7:0]  lvl;
  wire [6:0]  pre;
  wire [2:0]  modu;
  wire        wreq, r_al, o_al, h_al, e_vld, al_a, al_b, mute, beep, lamp, slf, on, spec, lgcy, burst, fw, irq;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         fw_n = 0;
  arc_top #(.UNIT_SERIAL(32'h0000_5A5A)) i_arc_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .ref_alarm_in(r_al), .oven_oscillator_alarm_in(o_al),
    .hw_alarm_in(h_al), .burst_option_in(bopt), .data_present_in(stat[0]), .clk_external_in(stat[1]),
    .clk_ok_in(stat[2]), .far_ebno_valid_in(e_vld), .far_ebno_db10_in(ebno), .alarm_a_out(al_a),
    .alarm_b_out(al_b), .carrier_mute_out(mute), .beep_out(beep), .lamp_test_out(lamp), .self_test_out(slf),
    .carrier_on_out(on), .modulation_out(modu), .spectrum_inv_out(spec), .legacy_mask_out(lgcy),
    .burst_mode_out(burst), .preamble_len_out(pre), .tx_level_out(lvl), .fw_update_start_out(fw), .irq_out(irq));
  arc_alarm_field i_arc_alarm_field (.fault_in(fault), .tx_level_in(lvl), .ref_alarm_out(r_al),
    .oven_alarm_out(o_al), .hw_alarm_out(h_al), .ebno_valid_out(e_vld), .ebno_db10_out(ebno));
  // clock and update-start pulse counter
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (fw === 1'b1) fw_n <= fw_n + 1;
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge sys_clk_in);
    while (wreq !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task settle;
    repeat (3) @(negedge sys_clk_in);
  endtask
  task set_fault(input [2:0] f);
    @(posedge sys_clk_in);
    fault <= f;
    settle;
  endtask
  // oscillator alarm codes, beep on either
  task t_route;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        bus(1'b1, `ARC_OFF_ROUTE, 32'hC00 | (s ? c << 3 : c));
        set_fault(s ? 3'b010 : 3'b001);
        chk({mute, al_b, al_a}, c);
        chk(beep, c[0] | c[1]);
        set_fault(3'b000);
      end
    end
    $display("routing test done");
  endtask
  // hardware alarm codes with beep selections
  task t_two;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `ARC_OFF_ROUTE, (c << 8) | ((c ^ 1) << 10));
      set_fault(3'b100);
      chk({mute, al_b, al_a}, c);
      chk(beep, c[1]);
      set_fault(3'b000);
    end
    $display("two-bit routing test done");
  endtask
  // test selections drive the test alarm
  task t_test;
    bus(1'b1, `ARC_OFF_ROUTE, 32'h040);
    for (int t = 0; t < 5; t++) begin
      bus(1'b1, `ARC_OFF_TEST, t % 4);
      settle;
      chk({slf, lamp}, t % 4);
      chk(al_a, t % 4 != 0);
    end
    $display("test select done");
  endtask
  task t_tx;
    int m[6] = '{0, 1, 2, 3, 6, 5};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `ARC_OFF_TXCFG, 32'h1 | (m[i] << 1));
      settle;
      chk({on, modu}, {1'b1, i == 5 ? 3'h6 : m[i][2:0]});
    end
    bus(1'b1, `ARC_OFF_TXCFG, 32'hF2);
    settle;
    chk({burst, lgcy, spec, on}, 4'b0110);
    @(posedge sys_clk_in);
    bopt <= 1'b1;
    bus(1'b1, `ARC_OFF_TXCFG, 32'hF2);
    settle;
    chk({burst, pre}, 8'hC0);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h72);
    settle;
    chk({burst, pre}, 8'hA0);
    @(posedge sys_clk_in);
    bopt <= 1'b0;
    settle;
    chk(burst, 0);
    $display("transmit settings done");
  endtask
  // manual policy holds the carrier off after a change
  task t_manual;
    bus(1'b1, `ARC_OFF_TXCFG, 32'h403);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h403);
    settle;
    chk(on, 1);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h405);
    bus(1'b0, `ARC_OFF_STATUS, 0);
    chk(rd[2:0], 3'b100);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h405);
    settle;
    chk(on, 1);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h003);
    $display("manual mute done");
  endtask
  // sticky status, mask and write-one clear
  task t_irq;
    bus(1'b1, `ARC_OFF_ROUTE, 32'h001);
    bus(1'b1, `ARC_OFF_IRQ_ST, 32'hF);
    set_fault(3'b001);
    set_fault(3'b000);
    bus(1'b0, `ARC_OFF_IRQ_ST, 0);
    chk(rd[3:0], 4'h1);
    bus(1'b1, `ARC_OFF_IRQ_MASK, 32'h0);
    settle;
    chk(irq, 0);
    bus(1'b1, `ARC_OFF_IRQ_MASK, 32'hF);
    settle;
    chk(irq, 1);
    bus(1'b1, `ARC_OFF_IRQ_ST, 32'h1);
    bus(1'b0, `ARC_OFF_IRQ_ST, 0);
    chk({irq, rd[3:0]}, 5'h0);
    $display("interrupt test done");
  endtask
  task t_fw_stat;
    bus(1'b1, `ARC_OFF_FWUPD, 32'h1);
    bus(1'b1, `ARC_OFF_SERIAL, 32'h0000_5A5B);
    bus(1'b1, `ARC_OFF_FWUPD, 32'h1);
    chk(fw_n, 0);
    bus(1'b1, `ARC_OFF_SERIAL, 32'h0000_5A5A);
    bus(1'b1, `ARC_OFF_FWUPD, 32'h1);
    settle;
    chk(fw_n, 1);
    @(posedge sys_clk_in);
    stat <= 3'b101;
    bus(1'b0, `ARC_OFF_STATUS, 0);
    chk(rd[6:0], 7'h2C);
    bus(1'b0, 4'hC, 0);
    chk(rd, 0);
    $display("update and status done");
  endtask
  // power loop limits and set point clamp
  task t_upc;
    bus(1'b1, `ARC_OFF_UPC, 32'h9070_01FF);
    bus(1'b1, `ARC_OFF_TXCFG, 32'h103);
    repeat (60) @(negedge sys_clk_in);
    chk(lvl, 8'h90);
    bus(1'b1, `ARC_OFF_UPC, 32'h9070_0005);
    repeat (60) @(negedge sys_clk_in);
    chk(lvl, 8'h70);
    bus(1'b0, `ARC_OFF_UPC, 0);
    chk(rd[8:0], `ARC_UPC_MIN_DB10);
    bus(1'b1, `ARC_OFF_UPC, 32'h9070_0041);
    repeat (60) @(negedge sys_clk_in);
    chk(lvl >= 8'h80 && lvl <= 8'h82, 1);
    $display("power loop done");
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    miscompares++;
    conclude;
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_route;
    t_two;
    t_test;
    t_tx;
    t_manual;
    t_irq;
    t_fw_stat;
    t_upc;
    conclude;
  end
endmodule
